// ### rtl/i2c_eeprom_master_sequencer.sv
// Byte-oriented two-wire master with Avalon-MM register access
`timescale 1ns/1ps

// Function
// - Transmit data write launches a transfer and clears transmit-empty
// - Transfer from idle begins with start, then slave address byte, then transmit byte on a write or received byte on a read
// - Transmit byte done sets transmit-empty and raises interrupt
// - Stop-after-write 0 holds bus without stop after an acknowledged transmit byte
// - Stop-after-write 1 issues stop right after transmit byte
// - Stop-after-read 0 issues no stop after received byte
// - Stop-after-read 1 issues stop once received byte is latched
// - Read launch clears receive-full; each received byte is latched
// - Latched byte sets receive-full and interrupts
// - Reading receive data register clears receive-full
// - Direction bit 0 means write, 1 means read
// - Speed bit selects standard rate at 0, fast rate at 1
// - Unanswered address sets bus error; write 1 clears it
// - Flag interrupts pass only when their enable bits are set
module i2c_eeprom_master_sequencer (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Interrupt to the microcontroller
  output logic             irq,
  // Serial clock, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  // Serial data, open drain
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  i2c_seq_pkg::ctrl_status_t csr_reg;
  i2c_seq_pkg::seq_state_t   state_reg;
  logic [7:0]  slave_address_register_reg;
  logic [7:0]  transmit_data_register_reg;
  logic [7:0]  receive_data_register_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [1:0]  phase_reg;
  logic        launch_pending_reg;
  logic        held_read_reg;
  logic        addr_phase_reg;
  logic        rx_mode_reg;
  logic        ack_reg;
  logic [31:0] readdata_reg;
  logic        waitrequest_reg;
  logic        irq_reg;
  logic        scl_oe_reg;
  logic        sda_oe_reg;
  logic        line_low_reg;
  logic        scl_s;
  logic        sda_s;
  logic        tick;

  // ------------------------------------------------------------------
  // Pin synchronisers and bit timer
  // ------------------------------------------------------------------
  bit_sync #(.WIDTH(2)) u_pin_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({scl_in, sda_in}),
    .sync_out ({scl_s, sda_s})
  );

  logic engine_run;
  logic stretch;
  assign engine_run = (state_reg == i2c_seq_pkg::ST_START) ||
                      (state_reg == i2c_seq_pkg::ST_BIT) ||
                      (state_reg == i2c_seq_pkg::ST_STOP);
  // A slave holding the clock low stalls the high phase
  assign stretch = engine_run && (phase_reg == i2c_seq_pkg::PH_HIGH) && !scl_s;

  quarter_timer u_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .run     (engine_run),
    .hold    (stretch),
    .fast    (csr_reg.fast_speed),
    .tick    (tick)
  );

  // ------------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------------
  logic acc_wr;
  logic acc_rd;
  logic wr_ctrl;
  logic wr_addr;
  logic wr_tx;
  logic rd_rx;
  assign acc_wr  = write && !waitrequest_reg && byteenable[0];
  assign acc_rd  = read && !waitrequest_reg;
  assign wr_ctrl = acc_wr && (address == i2c_seq_pkg::OFS_CTRL_STATUS);
  assign wr_addr = acc_wr && (address == i2c_seq_pkg::OFS_SLAVE_ADDR);
  assign wr_tx   = acc_wr && (address == i2c_seq_pkg::OFS_TX_DATA);
  assign rd_rx   = acc_rd && (address == i2c_seq_pkg::OFS_RX_DATA);

  function automatic logic [7:0] reg_mux(input logic [3:0] ofs);
    case (ofs)
      i2c_seq_pkg::OFS_CTRL_STATUS: reg_mux = csr_reg;
      i2c_seq_pkg::OFS_SLAVE_ADDR:  reg_mux = slave_address_register_reg;
      i2c_seq_pkg::OFS_RX_DATA:     reg_mux = receive_data_register_reg;
      default:                      reg_mux = i2c_seq_pkg::BYTE_ZERO;
    endcase
  endfunction : reg_mux

  // One wait cycle per access; read data stands at the accepting edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      waitrequest_reg <= 1'b1;
      readdata_reg    <= {i2c_seq_pkg::RD_PAD, i2c_seq_pkg::BYTE_ZERO};
    end else begin
      waitrequest_reg <= !((read || write) && waitrequest_reg);
      if (read && waitrequest_reg) begin
        readdata_reg <= {i2c_seq_pkg::RD_PAD, reg_mux(address)};
      end
    end
  end

  // ------------------------------------------------------------------
  // Byte completion events
  // ------------------------------------------------------------------
  logic byte_end;
  logic addr_end;
  logic tx_end;
  logic rx_end;
  logic dir_read;
  logic idle_or_hold;
  logic launch_go;
  logic need_addr;
  logic rx_next;
  assign byte_end = (state_reg == i2c_seq_pkg::ST_BIT) && tick &&
                    (phase_reg == i2c_seq_pkg::PH_FALL) && (bit_cnt_reg == i2c_seq_pkg::ACK_BIT_IDX);
  assign addr_end = byte_end && addr_phase_reg;
  assign tx_end   = byte_end && !addr_phase_reg && !rx_mode_reg;
  assign rx_end   = byte_end && !addr_phase_reg && rx_mode_reg;
  assign dir_read = slave_address_register_reg[i2c_seq_pkg::DIR_BIT] == i2c_seq_pkg::DIR_READ;
  assign idle_or_hold = (state_reg == i2c_seq_pkg::ST_IDLE) || (state_reg == i2c_seq_pkg::ST_HOLD);
  assign launch_go = launch_pending_reg && idle_or_hold;
  // A held write continues; anything else needs a (repeated) start
  assign need_addr = (state_reg == i2c_seq_pkg::ST_IDLE) || dir_read || held_read_reg;
  assign rx_next   = (state_reg == i2c_seq_pkg::ST_HOLD) && held_read_reg &&
                     !launch_pending_reg && !csr_reg.receive_full_flag;

  // ------------------------------------------------------------------
  // Control and status flags (set wins over clear)
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      csr_reg <= i2c_seq_pkg::CTRL_STATUS_RESET;
    end else begin
      if (wr_ctrl) begin
        csr_reg.stop_after_write          <= writedata[0];
        csr_reg.stop_after_read           <= writedata[1];
        csr_reg.transmit_interrupt_enable <= writedata[2];
        csr_reg.fast_speed                <= writedata[4];
        csr_reg.receive_interrupt_enable  <= writedata[6];
      end
      // Address refusal also frees the writer
      if (tx_end || (addr_end && (dir_read || ack_reg))) begin
        csr_reg.transmit_empty_flag <= 1'b1;
      end else if (wr_tx) begin
        csr_reg.transmit_empty_flag <= 1'b0;
      end
      if (rx_end) begin
        csr_reg.receive_full_flag <= 1'b1;
      end else if (rd_rx || (launch_go && dir_read)) begin
        csr_reg.receive_full_flag <= 1'b0;
      end
      if ((addr_end || tx_end) && ack_reg) begin
        csr_reg.bus_error <= 1'b1;
      end else if (wr_ctrl && writedata[i2c_seq_pkg::BUS_ERROR_BIT]) begin
        csr_reg.bus_error <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Data registers and launch request
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slave_address_register_reg <= i2c_seq_pkg::BYTE_ZERO;
      transmit_data_register_reg <= i2c_seq_pkg::BYTE_ZERO;
      receive_data_register_reg  <= i2c_seq_pkg::BYTE_ZERO;
      launch_pending_reg         <= 1'b0;
    end else begin
      if (wr_addr) begin
        slave_address_register_reg <= writedata[7:0];
      end
      if (wr_tx) begin
        transmit_data_register_reg <= writedata[7:0];
      end
      if (rx_end) begin
        receive_data_register_reg <= shift_reg;
      end
      // Read launches use the written byte only as a trigger
      if (wr_tx) begin
        launch_pending_reg <= 1'b1;
      end else if (launch_go) begin
        launch_pending_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Bit sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg      <= i2c_seq_pkg::ST_IDLE;
      phase_reg      <= i2c_seq_pkg::PH_SETUP;
      bit_cnt_reg    <= i2c_seq_pkg::BIT_FIRST;
      shift_reg      <= i2c_seq_pkg::BYTE_ZERO;
      scl_oe_reg     <= 1'b0;
      sda_oe_reg     <= 1'b0;
      addr_phase_reg <= 1'b0;
      rx_mode_reg    <= 1'b0;
      held_read_reg  <= 1'b0;
      ack_reg        <= 1'b0;
    end else begin
      if (engine_run && tick) begin
        phase_reg <= phase_reg + 2'h1;
      end
      case (state_reg)
        i2c_seq_pkg::ST_IDLE: begin
          if (launch_go) begin
            state_reg <= i2c_seq_pkg::ST_START;
          end
        end
        i2c_seq_pkg::ST_HOLD: begin
          if (launch_go && need_addr) begin
            state_reg <= i2c_seq_pkg::ST_START;
          end else if (launch_go) begin
            shift_reg   <= transmit_data_register_reg;
            rx_mode_reg <= 1'b0;
            bit_cnt_reg <= i2c_seq_pkg::BIT_FIRST;
            state_reg   <= i2c_seq_pkg::ST_BIT;
          end else if (rx_next) begin
            rx_mode_reg <= 1'b1;
            bit_cnt_reg <= i2c_seq_pkg::BIT_FIRST;
            state_reg   <= i2c_seq_pkg::ST_BIT;
          end
        end
        i2c_seq_pkg::ST_START: begin
          // Also serves as repeated start from a held bus
          if (tick) begin
            case (phase_reg)
              i2c_seq_pkg::PH_SETUP: sda_oe_reg <= 1'b0;
              i2c_seq_pkg::PH_RISE:  scl_oe_reg <= 1'b0;
              i2c_seq_pkg::PH_HIGH:  sda_oe_reg <= 1'b1;
              default: begin
                scl_oe_reg     <= 1'b1;
                shift_reg      <= slave_address_register_reg;
                addr_phase_reg <= 1'b1;
                rx_mode_reg    <= 1'b0;
                held_read_reg  <= 1'b0;
                bit_cnt_reg    <= i2c_seq_pkg::BIT_FIRST;
                state_reg      <= i2c_seq_pkg::ST_BIT;
              end
            endcase
          end
        end
        i2c_seq_pkg::ST_BIT: begin
          if (tick) begin
            case (phase_reg)
              i2c_seq_pkg::PH_SETUP: begin
                if (bit_cnt_reg == i2c_seq_pkg::ACK_BIT_IDX) begin
                  sda_oe_reg <= rx_mode_reg && !csr_reg.stop_after_read;
                end else begin
                  sda_oe_reg <= !rx_mode_reg && !shift_reg[7];
                end
              end
              i2c_seq_pkg::PH_RISE: scl_oe_reg <= 1'b0;
              i2c_seq_pkg::PH_HIGH: begin
                if (bit_cnt_reg == i2c_seq_pkg::ACK_BIT_IDX) begin
                  ack_reg <= sda_s;
                end else begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                end
              end
              default: begin
                scl_oe_reg <= 1'b1;
                if (bit_cnt_reg != i2c_seq_pkg::ACK_BIT_IDX) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end else if (addr_phase_reg) begin
                  addr_phase_reg <= 1'b0;
                  bit_cnt_reg    <= i2c_seq_pkg::BIT_FIRST;
                  if (ack_reg) begin
                    state_reg <= i2c_seq_pkg::ST_STOP;
                  end else if (dir_read) begin
                    rx_mode_reg <= 1'b1;
                  end else begin
                    shift_reg <= transmit_data_register_reg;
                  end
                end else if (rx_mode_reg) begin
                  held_read_reg <= 1'b1;
                  state_reg <= csr_reg.stop_after_read ? i2c_seq_pkg::ST_STOP :
                                                         i2c_seq_pkg::ST_HOLD;
                end else begin
                  state_reg <= (csr_reg.stop_after_write || ack_reg) ? i2c_seq_pkg::ST_STOP :
                                                                       i2c_seq_pkg::ST_HOLD;
                end
              end
            endcase
          end
        end
        i2c_seq_pkg::ST_STOP: begin
          if (tick) begin
            case (phase_reg)
              i2c_seq_pkg::PH_SETUP: sda_oe_reg <= 1'b1;
              i2c_seq_pkg::PH_RISE:  scl_oe_reg <= 1'b0;
              i2c_seq_pkg::PH_HIGH:  sda_oe_reg <= 1'b0;
              default: begin
                held_read_reg <= 1'b0;
                state_reg     <= i2c_seq_pkg::ST_IDLE;
              end
            endcase
          end
        end
        default: state_reg <= i2c_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_reg      <= 1'b0;
      line_low_reg <= 1'b0;
    end else begin
      irq_reg <= (csr_reg.transmit_empty_flag && csr_reg.transmit_interrupt_enable) ||
                 (csr_reg.receive_full_flag && csr_reg.receive_interrupt_enable);
      line_low_reg <= 1'b0;
    end
  end

  assign readdata    = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign irq         = irq_reg;
  assign scl_oe      = scl_oe_reg;
  assign sda_oe      = sda_oe_reg;
  assign scl_out     = line_low_reg;
  assign sda_out     = line_low_reg;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence seq_tx_hold;
    tx_end && !ack_reg && !csr_reg.stop_after_write;
  endsequence
  sequence seq_tx_stop;
    tx_end && csr_reg.stop_after_write;
  endsequence

  AST_TXE_CLEAR: assert property (wr_tx && !tx_end && !addr_end |=>
    !csr_reg.transmit_empty_flag && launch_pending_reg) else $error("transmit-empty not cleared");
  AST_START_COND: assert property (state_reg == i2c_seq_pkg::ST_START && tick &&
    phase_reg == i2c_seq_pkg::PH_HIGH |=> sda_oe_reg && !scl_oe_reg) else $error("bad start");
  AST_TXE_SET: assert property (tx_end |=> csr_reg.transmit_empty_flag)
    else $error("transmit-empty not set");
  AST_HOLD_NO_STOP: assert property (seq_tx_hold |=> state_reg == i2c_seq_pkg::ST_HOLD
    ##1 scl_oe_reg) else $error("bus not held");
  AST_STOP_WRITE: assert property (seq_tx_stop |=>
    state_reg == i2c_seq_pkg::ST_STOP && phase_reg == i2c_seq_pkg::PH_SETUP) else $error("no stop");
  AST_READ_HOLD: assert property (rx_end && !csr_reg.stop_after_read |=>
    state_reg == i2c_seq_pkg::ST_HOLD) else $error("stop after read");
  AST_READ_STOP: assert property (rx_end && csr_reg.stop_after_read |=>
    state_reg == i2c_seq_pkg::ST_STOP && receive_data_register_reg == $past(shift_reg))
    else $error("no stop after read");
  AST_RXF_LAUNCH: assert property (launch_go && dir_read && !rx_end |=>
    !csr_reg.receive_full_flag) else $error("receive-full not cleared at launch");
  AST_RXF_SET: assert property (rx_end |=> csr_reg.receive_full_flag ##1
    (irq_reg == csr_reg.receive_interrupt_enable || csr_reg.transmit_interrupt_enable))
    else $error("receive-full not set");
  AST_RXF_READ: assert property (rd_rx && !rx_end |=> !csr_reg.receive_full_flag)
    else $error("receive-full not cleared by read");
  AST_ERR_SET: assert property (addr_end && ack_reg |=> csr_reg.bus_error &&
    state_reg == i2c_seq_pkg::ST_STOP) else $error("bus error missed");
  AST_IRQ_GATED: assert property ((!csr_reg.transmit_interrupt_enable &&
    !csr_reg.receive_interrupt_enable)[*2] |-> !irq_reg) else $error("ungated interrupt");
  AST_MSB_FIRST: assert property (state_reg == i2c_seq_pkg::ST_BIT && tick && addr_phase_reg &&
    phase_reg == i2c_seq_pkg::PH_SETUP && bit_cnt_reg == i2c_seq_pkg::BIT_FIRST |=>
    sda_oe_reg == !$past(shift_reg[7])) else $error("bit order wrong");

endmodule : i2c_eeprom_master_sequencer

// ### rtl/i2c_seq_pkg.sv
// Constants, register map and types shared by the two-wire master sequencer
package i2c_seq_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned STD_RATE_HZ  = 100_000;
  localparam int unsigned FAST_RATE_HZ = 400_000;
  // Quarter bit periods round up so the bus never runs above its rate
  localparam int unsigned QTR_STD_CYC  = (CLK_HZ + 4 * STD_RATE_HZ - 1) / (4 * STD_RATE_HZ);
  localparam int unsigned QTR_FAST_CYC = (CLK_HZ + 4 * FAST_RATE_HZ - 1) / (4 * FAST_RATE_HZ);
  localparam int          QTR_CNT_W    = 5;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
  localparam logic [3:0] OFS_SLAVE_ADDR  = 4'h4;
  localparam logic [3:0] OFS_TX_DATA     = 4'h8;
  localparam logic [3:0] OFS_RX_DATA     = 4'hC;

  typedef struct packed {
    logic receive_full_flag;
    logic receive_interrupt_enable;
    logic bus_error;
    logic fast_speed;
    logic transmit_empty_flag;
    logic transmit_interrupt_enable;
    logic stop_after_read;
    logic stop_after_write;
  } ctrl_status_t;

  localparam logic [7:0] CTRL_STATUS_RESET = 8'h08;
  localparam logic [7:0] CTRL_WR_MASK      = 8'h57;
  localparam int         BUS_ERROR_BIT     = 5;
  localparam logic [7:0] BYTE_ZERO         = 8'h00;
  localparam logic [23:0] RD_PAD           = 24'h00_0000;

  // Slave address byte: direction in bit 0
  localparam int   DIR_BIT  = 0;
  localparam logic DIR_READ = 1'b1;

  // ------------------------------------------------------------------
  // Bit engine
  // ------------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST   = 4'h0;
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  localparam logic [1:0] PH_SETUP    = 2'h0;
  localparam logic [1:0] PH_RISE     = 2'h1;
  localparam logic [1:0] PH_HIGH     = 2'h2;
  localparam logic [1:0] PH_FALL     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_STOP,
    ST_HOLD
  } seq_state_t;

endpackage : i2c_seq_pkg

// ### rtl/bit_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // Idle bus lines read high, so reset to ones
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : bit_sync

// ### rtl/quarter_timer.sv
// Quarter bit period tick generator with standard and fast rates
`timescale 1ns/1ps
module quarter_timer (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Control
  input  wire logic run,
  input  wire logic hold,
  input  wire logic fast,
  // Tick
  output logic      tick
);

  logic [i2c_seq_pkg::QTR_CNT_W-1:0] cnt_reg;

  function automatic logic [i2c_seq_pkg::QTR_CNT_W-1:0] reload(input logic sel_fast);
    if (sel_fast) begin
      reload = i2c_seq_pkg::QTR_CNT_W'(i2c_seq_pkg::QTR_FAST_CYC - 1);
    end else begin
      reload = i2c_seq_pkg::QTR_CNT_W'(i2c_seq_pkg::QTR_STD_CYC - 1);
    end
  endfunction : reload

  // Hold freezes the count while a slave stretches the clock
  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      cnt_reg <= reload(fast);
      tick    <= 1'b0;
    end else if (hold) begin
      tick    <= 1'b0;
    end else if (cnt_reg == '0) begin
      cnt_reg <= reload(fast);
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 1'b1;
      tick    <= 1'b0;
    end
  end

endmodule : quarter_timer

// ### tb/eeprom_model.sv
// Behavioural serial memory on the two-wire bus, open drain
`timescale 1ns/1ps
module eeprom_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  // Bus levels
  input  wire logic       scl,
  input  wire logic       sda,
  // Data line pull-down
  output logic            pull,
  // Observation
  output logic [7:0]      rx_byte,
  output logic            got,
  output int              stops
);
  logic [7:0] sh, ptr;
  logic       act, rd, adr, nak, busy;
  int         n;
  initial begin
    pull = 1'b0; act = 1'b0; got = 1'b0; stops = 0; ptr = 8'h00; busy = 1'b0;
  end
  // The clock fall that closes a start is not a data bit
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1; adr = 1'b1; rd = 1'b0; nak = 1'b0; n = -1; pull = 1'b0; busy = 1'b1;
  end
  // Both lines leaving unknown together at power-up is no stop
  always @(posedge sda) if (scl === 1'b1 && busy) begin
    stops++;
    busy = 1'b0;
    act = 1'b0;
    pull = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (rd) nak = sda;
  end
  // Address mismatch leaves the line released so the master sees no answer
  always @(negedge scl) if (act) begin
    n++;
    if (n == 8 && !rd) begin
      rx_byte = sh;
      got = ~got;
      if (adr) begin
        rd = sh[0];
        act = (sh[7:1] == DEV);
      end else ptr = sh;
      adr = 1'b0;
      pull = act;
    end else if (n == 8) begin
      pull = 1'b0;
      ptr++;
    end else if (n == 9) begin
      n = 0;
      if (nak) act = 1'b0;
      pull = act & rd & ~ptr[7];
    end else if (rd) pull = ~ptr[7-n];
  end
endmodule : eeprom_model

// ### tb/test_i2c_eeprom_master_sequencer.sv
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/1ps
module test_i2c_eeprom_master_sequencer;
  localparam logic [6:0] DEV = 7'h50;
  localparam logic [3:0] CS = i2c_seq_pkg::OFS_CTRL_STATUS;
  localparam logic [3:0] TX = i2c_seq_pkg::OFS_TX_DATA;
  logic        clk_sys, reset, read, write, irq, waitrequest, scl_oe, sda_oe, pull, got;
  logic        scl_out, sda_out;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic [7:0]  rx_byte, e;
  logic [7:0]  exp_q[$];
  int          error_cnt, tests_run, stops, seed, k;
  wire         scl = scl_oe ? scl_out : 1'b1;
  wire         sda = (sda_oe ? sda_out : 1'b1) & ~pull;
  i2c_eeprom_master_sequencer uut (.clk_sys, .reset, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .irq, .scl_in(scl), .scl_out, .scl_oe,
    .sda_in(sda), .sda_out, .sda_oe);
  eeprom_model #(.DEV(DEV)) mem (.scl, .sda, .pull, .rx_byte, .got, .stops);
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    tests_run++;
    if (s !== ex) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk
  // One wait state per access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    address <= a; write <= w; read <= ~w; writedata <= {24'h00_0000, d};
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0; write <= 1'b0;
  endtask : bus
  task automatic poll(input int b);
    repeat (3000) begin
      bus(1'b0, CS, 8'h00);
      if (q[b] === 1'b1) break;
    end
    chk("status flag", 1'b1, q[b]);
  endtask : poll
  task automatic send(input logic [7:0] d);
    exp_q.push_back(d);
    bus(1'b1, TX, d);
    poll(3);
  endtask : send
  task automatic stop_wait(input int n);
    repeat (2000) if (stops != n) @(posedge clk_sys);
    chk("stop count", n, stops);
  endtask : stop_wait
  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  always @(got) if ($time > 0) begin
    e = exp_q.pop_front();
    chk("wire byte", e, rx_byte);
  end
  initial begin
    #(100 * 80000);
    error_cnt++;
    wrap_up;
  end
  initial begin
    seed = 32'h739dbc3a; clk_sys = 0; reset = 1; address = 0; read = 0; write = 0;
    writedata = 0; byteenable = 4'h1;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    bus(1'b0, CS, 8'h00);
    chk("status reset", 32'h0000_0008, q);
    bus(1'b0, 4'h2, 8'h00);
    chk("unmapped read", 32'h0000_0000, q);
    // Page write: address, word address, three data bytes, stop on the last
    bus(1'b1, CS, 8'h14);
    bus(1'b1, i2c_seq_pkg::OFS_SLAVE_ADDR, {DEV, 1'b0});
    exp_q.push_back({DEV, 1'b0});
    send(8'h00);
    send(8'h40);
    chk("held bus", 0, stops);
    for (k = 0; k < 3; k++) begin
      if (k == 2) bus(1'b1, CS, 8'h15);
      send(8'($random(seed)));
    end
    stop_wait(1);
    chk("irq enabled", 1'b1, irq);
    bus(1'b1, CS, 8'h10);
    @(posedge clk_sys);
    @(posedge clk_sys);
    chk("irq masked", 1'b0, irq);
    // Random read: dummy write of the word address, then sequential read
    bus(1'b1, i2c_seq_pkg::OFS_SLAVE_ADDR, {DEV, 1'b0});
    exp_q.push_back({DEV, 1'b0});
    send(8'h00);
    send(8'h40);
    bus(1'b1, i2c_seq_pkg::OFS_SLAVE_ADDR, {DEV, 1'b1});
    exp_q.push_back({DEV, 1'b1});
    bus(1'b1, CS, 8'h50);
    bus(1'b1, TX, 8'($random(seed)));
    for (k = 0; k < 3; k++) begin
      poll(7);
      chk("rx irq", 1'b1, irq);
      if (k == 1) bus(1'b1, CS, 8'h52);
      bus(1'b0, i2c_seq_pkg::OFS_RX_DATA, 8'h00);
      chk("rx data", 8'h40 + k, q);
      bus(1'b0, CS, 8'h00);
      chk("rx full cleared", 1'b0, q[7]);
    end
    stop_wait(2);
    // Unanswered address raises bus error, cleared only by writing one
    bus(1'b1, i2c_seq_pkg::OFS_SLAVE_ADDR, 8'h42);
    exp_q.push_back(8'h42);
    bus(1'b1, CS, 8'h00);
    bus(1'b1, TX, 8'h00);
    poll(5);
    bus(1'b1, CS, 8'h10);
    bus(1'b0, CS, 8'h00);
    chk("error kept", 1'b1, q[5]);
    bus(1'b1, CS, 8'h30);
    bus(1'b0, CS, 8'h00);
    chk("error cleared", 1'b0, q[5]);
    chk("bytes left", 0, exp_q.size());
    wrap_up;
  end
endmodule : test_i2c_eeprom_master_sequencer
